/* File: design/spi_isolated_pulse_bridge.sv */
// bridge between four-wire SPI and a twisted-pair pulse link, one or two channels
// assumes all pins synchronous to clk_sys and straps settled at reset release
`timescale 1ns/1ps
module spi_isolated_pulse_bridge
    import bridge_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter logic [TMO_W-1:0] TIMEOUT_BASE_CYCLES = 32'h000F4240
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // straps and resistor-set selectors
    input wire logic [CHANNELS-1:0] role_select_strap,
    input wire logic [CHANNELS-1:0][CFG_W-1:0] phase_polarity_select,
    input wire logic [CHANNELS-1:0][CFG_W-1:0] link_mode_select,
    input wire logic [CHANNELS-1:0][CFG_W-1:0] lowpower_timeout_select,
    // chip select pin, active low
    input wire logic [CHANNELS-1:0] cs_n_in,
    output logic [CHANNELS-1:0] cs_n_out,
    output logic [CHANNELS-1:0] cs_n_oe_n,
    // serial clock pin
    input wire logic [CHANNELS-1:0] sclk_in,
    output logic [CHANNELS-1:0] sclk_out,
    output logic [CHANNELS-1:0] sclk_oe_n,
    // controller-to-peripheral data pin
    input wire logic [CHANNELS-1:0] ctp_in,
    output logic [CHANNELS-1:0] ctp_out,
    output logic [CHANNELS-1:0] ctp_oe_n,
    // peripheral-to-controller data pin
    input wire logic [CHANNELS-1:0] ptc_in,
    output logic [CHANNELS-1:0] ptc_out,
    output logic [CHANNELS-1:0] ptc_oe_n,
    // twisted-pair line, comparator levels in, drive levels out
    input wire logic [CHANNELS-1:0] line_plus_in,
    input wire logic [CHANNELS-1:0] line_minus_in,
    output logic [CHANNELS-1:0] line_plus_out,
    output logic [CHANNELS-1:0] line_minus_out,
    output logic [CHANNELS-1:0] line_oe_n,
    // low-power monitoring alert
    output logic [CHANNELS-1:0] timeout_alert_out
);

    ////////////////////////////////////////////////////////////////////////////
    // one independent channel per generate entry
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
        chan_state_type state_ff;
        chan_state_type nxt_state;
        logic req;
        logic req_long;
        logic req_pos;
        logic latch_lvl;
        logic [TMO_W-1:0] tmo_limit;
        pulse_rx_if rx_bus ();

        pulse_receiver u_rx (
            .clk_sys(clk_sys),
            .reset(reset),
            .line_plus_in(line_plus_in[ch]),
            .line_minus_in(line_minus_in[ch]),
            .rx(rx_bus.rcv)
        );

        // receiver deaf while we drive the pair
        assign rx_bus.hold = (state_ff.tx_state != TX_IDLE);

        always_comb
        begin
            nxt_state = state_ff;
            req = 1'b0;
            req_long = 1'b0;
            req_pos = 1'b0;
            // modes 0 and 3 latch on rising edge, 1 and 2 on falling
            latch_lvl = (state_ff.pha == state_ff.pol);
            tmo_limit = TIMEOUT_BASE_CYCLES << state_ff.tmo_sel;
            if (!state_ff.cfg_done)
            begin
                // one capture only; later strap changes are ignored
                nxt_state.cfg_done = 1'b1;
                nxt_state.role = role_select_strap[ch];
                nxt_state.pha = phase_polarity_select[ch][PHA_BIT];
                nxt_state.pol = phase_polarity_select[ch][POL_BIT];
                nxt_state.mode = link_mode_select[ch];
                nxt_state.tmo_sel = lowpower_timeout_select[ch];
                nxt_state.cs_prev = cs_n_in[ch];
                nxt_state.sclk_prev = sclk_in[ch];
                nxt_state.sclk_out = phase_polarity_select[ch][POL_BIT];
                nxt_state.cs_n_oe_n = role_select_strap[ch];
                nxt_state.sclk_oe_n = role_select_strap[ch];
                nxt_state.ctp_oe_n = role_select_strap[ch];
                nxt_state.ptc_oe_n = !role_select_strap[ch];
            end
            else
            begin
                ////////////////////////////////////////////////////////////////
                // pulse transmitter
                case (state_ff.tx_state)
                    TX_IDLE:
                    begin
                        if (state_ff.pend_valid)
                        begin
                            nxt_state.pend_valid = 1'b0;
                            nxt_state.tx_long = state_ff.pend_long;
                            nxt_state.tx_cnt = state_ff.pend_long ? LONG_HALF_CYC
                                                                  : SHORT_HALF_CYC;
                            nxt_state.line_plus = state_ff.pend_pos;
                            nxt_state.line_minus = !state_ff.pend_pos;
                            nxt_state.line_oe_n = 1'b0;
                            nxt_state.tx_state = TX_FIRST;
                        end
                    end
                    TX_FIRST:
                    begin
                        if (state_ff.tx_cnt == CNT_ONE)
                        begin
                            // opposite half keeps the pair free of DC
                            nxt_state.line_plus = state_ff.line_minus;
                            nxt_state.line_minus = state_ff.line_plus;
                            nxt_state.tx_cnt = state_ff.tx_long ? LONG_HALF_CYC
                                                                : SHORT_HALF_CYC;
                            nxt_state.tx_state = TX_SECOND;
                        end
                        else
                            nxt_state.tx_cnt = state_ff.tx_cnt - CNT_ONE;
                    end
                    TX_SECOND:
                    begin
                        if (state_ff.tx_cnt == CNT_ONE)
                        begin
                            // release to bias, the zero ending level
                            nxt_state.line_plus = 1'b0;
                            nxt_state.line_minus = 1'b0;
                            nxt_state.line_oe_n = 1'b1;
                            nxt_state.tx_state = TX_IDLE;
                        end
                        else
                            nxt_state.tx_cnt = state_ff.tx_cnt - CNT_ONE;
                    end
                    default:
                        nxt_state.tx_state = TX_IDLE;
                endcase

                ////////////////////////////////////////////////////////////////
                // role behaviour
                if (state_ff.role)
                begin
                    nxt_state.cs_prev = cs_n_in[ch];
                    nxt_state.sclk_prev = sclk_in[ch];
                    if (cs_n_in[ch] != state_ff.cs_prev)
                    begin
                        req = 1'b1;
                        req_long = 1'b1;
                        req_pos = cs_n_in[ch];
                        nxt_state.ptc_out = 1'b1;
                    end
                    else if (!cs_n_in[ch] && sclk_in[ch] != state_ff.sclk_prev
                             && sclk_in[ch] == latch_lvl)
                    begin
                        req = 1'b1;
                        req_pos = ctp_in[ch];
                        // null answer reads as 1 until a -1 arrives
                        nxt_state.ptc_out = 1'b1;
                    end
                    if (rx_bus.valid && !rx_bus.is_long && !rx_bus.is_pos)
                        nxt_state.ptc_out = 1'b0;
                end
                else
                begin
                    if (rx_bus.valid && rx_bus.is_long)
                    begin
                        nxt_state.cs_n_out = rx_bus.is_pos;
                        if (rx_bus.is_pos)
                        begin
                            nxt_state.sclk_out = state_ff.pol;
                            nxt_state.p_state = PS_IDLE;
                        end
                        else
                        begin
                            // phase 1 leaves idle level at select fall
                            if (state_ff.pha)
                                nxt_state.sclk_out = !state_ff.pol;
                            nxt_state.p_cnt = CS_RETURN_CYC;
                            nxt_state.p_state = PS_RET;
                        end
                    end
                    else if (rx_bus.valid && !state_ff.cs_n_out)
                    begin
                        nxt_state.ctp_out = rx_bus.is_pos;
                        nxt_state.p_cnt = SCLK_SETUP_CYC;
                        nxt_state.p_state = PS_SETUP;
                    end
                    else
                    begin
                        case (state_ff.p_state)
                            PS_SETUP:
                            begin
                                if (state_ff.p_cnt == CNT_ONE)
                                begin
                                    nxt_state.sclk_out = !state_ff.sclk_out;
                                    nxt_state.p_cnt = SCLK_PULSE_CYC;
                                    nxt_state.p_state = PS_CLK;
                                end
                                else
                                    nxt_state.p_cnt = state_ff.p_cnt - CNT_ONE;
                            end
                            PS_CLK:
                            begin
                                if (state_ff.p_cnt == CNT_ONE)
                                begin
                                    nxt_state.sclk_out = !state_ff.sclk_out;
                                    nxt_state.p_cnt = CNT_ONE;
                                    nxt_state.p_state = PS_RET;
                                end
                                else
                                    nxt_state.p_cnt = state_ff.p_cnt - CNT_ONE;
                            end
                            PS_RET:
                            begin
                                if (state_ff.p_cnt == CNT_ONE)
                                begin
                                    // a 1 is never sent, so several can share a cable
                                    if (!ptc_in[ch] && state_ff.mode != MODE_UNIDIR)
                                        req = 1'b1;
                                    nxt_state.p_state = PS_IDLE;
                                end
                                else
                                    nxt_state.p_cnt = state_ff.p_cnt - CNT_ONE;
                            end
                            default:
                                nxt_state.p_state = PS_IDLE;
                        endcase
                    end
                end

                // single pending slot; a request while it is full is lost
                if (req && !nxt_state.pend_valid)
                begin
                    nxt_state.pend_valid = 1'b1;
                    nxt_state.pend_long = req_long;
                    nxt_state.pend_pos = req_pos;
                end

                ////////////////////////////////////////////////////////////////
                // link-silence timeout
                if (rx_bus.valid)
                begin
                    nxt_state.tmo_cnt = '0;
                    nxt_state.alert = 1'b0;
                end
                else if (state_ff.tmo_cnt >= tmo_limit - 32'h00000001)
                    nxt_state.alert = 1'b1;
                else
                    nxt_state.tmo_cnt = state_ff.tmo_cnt + 32'h00000001;
            end
        end

        always_ff @(posedge clk_sys or posedge reset)
        begin
            if (reset)
                state_ff <= CHAN_RESET;
            else
                state_ff <= nxt_state;
        end

        assign cs_n_out[ch] = state_ff.cs_n_out;
        assign cs_n_oe_n[ch] = state_ff.cs_n_oe_n;
        assign sclk_out[ch] = state_ff.sclk_out;
        assign sclk_oe_n[ch] = state_ff.sclk_oe_n;
        assign ctp_out[ch] = state_ff.ctp_out;
        assign ctp_oe_n[ch] = state_ff.ctp_oe_n;
        assign ptc_out[ch] = state_ff.ptc_out;
        assign ptc_oe_n[ch] = state_ff.ptc_oe_n;
        assign line_plus_out[ch] = state_ff.line_plus;
        assign line_minus_out[ch] = state_ff.line_minus;
        assign line_oe_n[ch] = state_ff.line_oe_n;
        assign timeout_alert_out[ch] = state_ff.alert;
    end

endmodule : spi_isolated_pulse_bridge

/* File: design/bridge_pkg.sv */
// constants, enums and state types for the SPI to pulse-link bridge
// assumes a single 100 MHz system clock; all times become cycle counts here
package bridge_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and time bases
    localparam int CLK_MHZ = 100;
    localparam int NS_PER_US = 1000;
    localparam int ROUND_UP = NS_PER_US - 1;
    localparam int CNT_W = 8;

    // transmitted half-pulse widths
    localparam int LONG_HALF_NS = 150;
    localparam int SHORT_HALF_NS = 50;
    // receive windows for one half-pulse
    localparam int SHORT_MIN_NS = 30;
    localparam int LONG_MIN_NS = 100;
    localparam int LONG_MAX_NS = 250;
    // peripheral-side clock shaping
    localparam int SCLK_SETUP_NS = 125;
    localparam int SCLK_PULSE_NS = 125;
    localparam int CS_RETURN_NS = 220;

    localparam logic [CNT_W-1:0] LONG_HALF_CYC = CNT_W'(LONG_HALF_NS * CLK_MHZ / NS_PER_US);
    localparam logic [CNT_W-1:0] SHORT_HALF_CYC = CNT_W'(SHORT_HALF_NS * CLK_MHZ / NS_PER_US);
    localparam logic [CNT_W-1:0] SHORT_MIN_CYC =
        CNT_W'((SHORT_MIN_NS * CLK_MHZ + ROUND_UP) / NS_PER_US);
    localparam logic [CNT_W-1:0] LONG_MIN_CYC =
        CNT_W'((LONG_MIN_NS * CLK_MHZ + ROUND_UP) / NS_PER_US);
    localparam logic [CNT_W-1:0] LONG_MAX_CYC = CNT_W'(LONG_MAX_NS * CLK_MHZ / NS_PER_US);
    localparam logic [CNT_W-1:0] SCLK_SETUP_CYC =
        CNT_W'((SCLK_SETUP_NS * CLK_MHZ + ROUND_UP) / NS_PER_US);
    localparam logic [CNT_W-1:0] SCLK_PULSE_CYC =
        CNT_W'((SCLK_PULSE_NS * CLK_MHZ + ROUND_UP) / NS_PER_US);
    localparam logic [CNT_W-1:0] CS_RETURN_CYC =
        CNT_W'((CS_RETURN_NS * CLK_MHZ + ROUND_UP) / NS_PER_US);
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // resistor-set selector codes
    localparam int CFG_W = 2;
    localparam int PHA_BIT = 0;
    localparam int POL_BIT = 1;
    localparam logic [CFG_W-1:0] MODE_UNIDIR = 2'h2;
    localparam int TMO_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {SYM_NULL, SYM_POS, SYM_NEG} sym_type;
    typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} tx_state_type;
    typedef enum logic [1:0] {PS_IDLE, PS_SETUP, PS_CLK, PS_RET} per_state_type;

    typedef struct packed {
        sym_type lvl;
        logic [CNT_W-1:0] cnt;
        logic second;
        logic valid;
        logic is_long;
        logic is_pos;
    } rx_state_type;

    typedef struct packed {
        logic cfg_done;
        logic role;
        logic pha;
        logic pol;
        logic [CFG_W-1:0] mode;
        logic [CFG_W-1:0] tmo_sel;
        logic cs_prev;
        logic sclk_prev;
        tx_state_type tx_state;
        logic [CNT_W-1:0] tx_cnt;
        logic tx_long;
        logic pend_valid;
        logic pend_long;
        logic pend_pos;
        per_state_type p_state;
        logic [CNT_W-1:0] p_cnt;
        logic cs_n_out;
        logic cs_n_oe_n;
        logic sclk_out;
        logic sclk_oe_n;
        logic ctp_out;
        logic ctp_oe_n;
        logic ptc_out;
        logic ptc_oe_n;
        logic line_plus;
        logic line_minus;
        logic line_oe_n;
        logic [TMO_W-1:0] tmo_cnt;
        logic alert;
    } chan_state_type;

    localparam chan_state_type CHAN_RESET = '{
        tx_state: TX_IDLE, p_state: PS_IDLE,
        cs_prev: 1'b1, cs_n_out: 1'b1, ptc_out: 1'b1,
        cs_n_oe_n: 1'b1, sclk_oe_n: 1'b1, ctp_oe_n: 1'b1, ptc_oe_n: 1'b1,
        line_oe_n: 1'b1, default: '0};

endpackage : bridge_pkg

/* File: design/pulse_rx_if.sv */
// decoded pulse hand-off between the line receiver and the channel logic
// assumes both ends sit on clk_sys
`timescale 1ns/1ps
interface pulse_rx_if;
    logic valid;
    logic is_long;
    logic is_pos;
    logic hold;
    modport rcv (output valid, output is_long, output is_pos, input hold);
    modport use_side (input valid, input is_long, input is_pos, output hold);
endinterface : pulse_rx_if

/* File: design/pulse_receiver.sv */
// line-level classifier and half-pulse width timers
// assumes comparator outputs synchronous to clk_sys
`timescale 1ns/1ps
module pulse_receiver
    import bridge_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // comparator levels
    input wire logic line_plus_in,
    input wire logic line_minus_in,
    // decoded pulses
    pulse_rx_if.rcv rx
);
    rx_state_type state_ff;
    rx_state_type nxt_state;
    sym_type cur;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // both or neither above threshold reads as null
        if (line_plus_in && !line_minus_in)
            cur = SYM_POS;
        else if (!line_plus_in && line_minus_in)
            cur = SYM_NEG;
        else
            cur = SYM_NULL;
        nxt_state = state_ff;
        nxt_state.valid = 1'b0;
        if (rx.hold)
        begin
            // own transmission would echo back as a pulse
            nxt_state.lvl = SYM_NULL;
            nxt_state.cnt = '0;
            nxt_state.second = 1'b0;
        end
        else if (cur == state_ff.lvl)
        begin
            if (state_ff.cnt != CNT_MAX)
                nxt_state.cnt = state_ff.cnt + CNT_ONE;
        end
        else
        begin
            if (state_ff.lvl != SYM_NULL && cur != SYM_NULL && !state_ff.second)
            begin
                nxt_state.is_pos = (state_ff.lvl == SYM_POS);
                if (state_ff.cnt >= SHORT_MIN_CYC && state_ff.cnt < LONG_MIN_CYC)
                begin
                    nxt_state.valid = 1'b1;
                    nxt_state.is_long = 1'b0;
                end
                else if (state_ff.cnt >= LONG_MIN_CYC && state_ff.cnt <= LONG_MAX_CYC)
                begin
                    nxt_state.valid = 1'b1;
                    nxt_state.is_long = 1'b1;
                end
                // any other width fails both timers and is dropped
            end
            nxt_state.second = (state_ff.lvl != SYM_NULL && cur != SYM_NULL);
            nxt_state.lvl = cur;
            nxt_state.cnt = CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            state_ff <= '{lvl: SYM_NULL, default: '0};
        else
            state_ff <= nxt_state;
    end

    assign rx.valid = state_ff.valid;
    assign rx.is_long = state_ff.is_long;
    assign rx.is_pos = state_ff.is_pos;

endmodule : pulse_receiver

/* File: verif/bridge_assertions.sv */
// concurrent checks on the bridge top ports, bound into the top module
// assumes straps steady after reset; channel 0 controller, channel 1 peripheral
`timescale 1ns/1ps
module bridge_assertions
    import bridge_pkg::*;
#(
    parameter int CHANNELS = 2
)
(
    // clock, reset, straps
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [CHANNELS-1:0] role_select_strap,
    input wire logic [CHANNELS-1:0][CFG_W-1:0] phase_polarity_select,
    // pins
    input wire logic [CHANNELS-1:0] cs_n_in,
    input wire logic [CHANNELS-1:0] sclk_in,
    input wire logic [CHANNELS-1:0] ctp_in,
    input wire logic [CHANNELS-1:0] line_plus_in,
    input wire logic [CHANNELS-1:0] line_minus_in,
    input wire logic [CHANNELS-1:0] cs_n_out,
    input wire logic [CHANNELS-1:0] cs_n_oe_n,
    input wire logic [CHANNELS-1:0] ctp_oe_n,
    input wire logic [CHANNELS-1:0] ptc_out,
    input wire logic [CHANNELS-1:0] ptc_oe_n,
    input wire logic [CHANNELS-1:0] line_plus_out,
    input wire logic [CHANNELS-1:0] line_minus_out,
    input wire logic [CHANNELS-1:0] line_oe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    AST_IDLE_ZERO: assert property ((line_oe_n & (line_plus_out | line_minus_out)) == '0)
        else $error("line level while released");
    AST_ONE_LEVEL: assert property (
        (~line_oe_n & ~(line_plus_out ^ line_minus_out)) == '0)
        else $error("pulse half without single level");
    AST_HALF_HOLD: assert property (
        $fell(line_oe_n[0]) |=> $stable({line_plus_out[0], line_minus_out[0]})[*4])
        else $error("half pulse too short");
    AST_SEL_PULSE: assert property (
        role_select_strap[0] && $fell(cs_n_in[0]) |-> ##2 !line_oe_n[0] && line_minus_out[0])
        else $error("select fall not sent as -1");
    AST_LATCH_PULSE: assert property (
        role_select_strap[0] && !(^phase_polarity_select[0]) && !cs_n_in[0] && $stable(cs_n_in[0])
        && $rose(sclk_in[0]) |-> ##2 !line_oe_n[0] && line_plus_out[0] == $past(ctp_in[0], 2))
        else $error("latched bit sent wrong");
    AST_RET_ONE: assert property (
        role_select_strap[0] && $changed(cs_n_in[0]) |-> ##[1:2] ptc_out[0])
        else $error("returned data not preset to one");
    AST_PER_RET: assert property (
        !role_select_strap[1] && $fell(line_oe_n[1])
        |-> line_minus_out[1] ##5 line_plus_out[1] ##5 line_oe_n[1])
        else $error("peripheral return not short -1");
    AST_PER_CS: assert property (
        !role_select_strap[1] && $changed(cs_n_out[1])
        |-> (line_plus_in[1] ^ line_minus_in[1]) && cs_n_out[1] == line_minus_in[1])
        else $error("select out moved without long pulse");
    AST_PINS_HELD: assert property (
        !$past(reset, 2) |-> $stable({cs_n_oe_n, ctp_oe_n, ptc_oe_n}) && ptc_oe_n == ~cs_n_oe_n)
        else $error("pin directions moved");
    COV_SEL: cover property ($fell(cs_n_out[1]));
    COV_RET: cover property ($fell(line_oe_n[1]));
    COV_RX0: cover property ($fell(ptc_out[0]));
endmodule : bridge_assertions

bind spi_isolated_pulse_bridge bridge_assertions #(.CHANNELS(CHANNELS)) i_chk (
    .clk_sys, .reset, .role_select_strap, .phase_polarity_select, .cs_n_in, .sclk_in,
    .ctp_in, .line_plus_in, .line_minus_in, .cs_n_out, .cs_n_oe_n, .ctp_oe_n, .ptc_out,
    .ptc_oe_n, .line_plus_out, .line_minus_out, .line_oe_n);

/* File: verif/far_link_model.sv */
// far-end link transmitter, drives comparator levels of one channel
// assumes clk_sys sampling; a released line reads as null through the bias
`timescale 1ns/1ps
module far_link_model
(
    // clock
    input wire logic clk_sys,
    // comparator levels
    output logic plus,
    output logic minus
);
    initial {plus, minus} = 2'h0;
    // widths outside the windows let the bench probe rejection
    task send(input logic pos, input int n);
        @(posedge clk_sys);
        {plus, minus} <= {pos, ~pos};
        repeat (n) @(posedge clk_sys);
        {plus, minus} <= {~pos, pos};
        repeat (n) @(posedge clk_sys);
        {plus, minus} <= 2'h0;
    endtask : send
endmodule : far_link_model

/* File: verif/spi_isolated_pulse_bridge_tb_top.sv */
// bench: channel 0 controller cabled to channel 1 peripheral, far model on ch0
// assumes 100 MHz clk_sys and a shortened timeout base
`timescale 1ns/1ps
module spi_isolated_pulse_bridge_tb_top;
    logic clk_sys, reset, fp, fm;
    logic [1:0] role_select_strap, cs_n_in, sclk_in, ctp_in, ptc_in, timeout_alert_out;
    logic [1:0][1:0] phase_polarity_select, link_mode_select, lowpower_timeout_select;
    logic [1:0] cs_n_out, cs_n_oe_n, sclk_out, sclk_oe_n, ctp_out, ctp_oe_n, ptc_out, ptc_oe_n;
    logic [1:0] line_plus_in, line_minus_in, line_plus_out, line_minus_out, line_oe_n;
    int n_fail, checks_done;
    int wid[3] = '{2, 26, 3};
    logic [15:0] exp_rx[3] = '{16'h3, 16'h3, 16'h0};
    // the cable: each channel hears the other, far model shares channel 0
    assign line_plus_in = {line_plus_out[0], line_plus_out[1] | fp};
    assign line_minus_in = {line_minus_out[0], line_minus_out[1] | fm};
    spi_isolated_pulse_bridge #(.CHANNELS(2), .TIMEOUT_BASE_CYCLES(32'h00000040)) i_dut (
        .clk_sys, .reset, .role_select_strap, .phase_polarity_select, .link_mode_select,
        .lowpower_timeout_select, .cs_n_in, .cs_n_out, .cs_n_oe_n, .sclk_in, .sclk_out,
        .sclk_oe_n, .ctp_in, .ctp_out, .ctp_oe_n, .ptc_in, .ptc_out, .ptc_oe_n, .line_plus_in,
        .line_minus_in, .line_plus_out, .line_minus_out, .line_oe_n, .timeout_alert_out);
    far_link_model i_far (.clk_sys(clk_sys), .plus(fp), .minus(fm));
    ////////////////////////////////////////
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task chk_pulse(input logic pos, input logic [7:0] half);
        int n;
        for (n = 0; n < 90 && line_oe_n[0] !== 1'b0; n++) @(negedge clk_sys);
        for (n = 0; {line_plus_out[0], line_minus_out[0]} === {pos, ~pos}; n++) @(negedge clk_sys);
        cmp(n[7:0], half);
        for (n = 0; {line_plus_out[0], line_minus_out[0]} === {~pos, pos}; n++) @(negedge clk_sys);
        cmp(n[7:0], half);
        cmp({line_oe_n[0], line_plus_out[0], line_minus_out[0]}, 16'h4);
    endtask : chk_pulse
    task end_sim;
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // whole run is near 500 cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        end_sim;
    end
    initial
    begin
        reset = 1'b1;
        role_select_strap = 2'b01;
        phase_polarity_select = {2'h2, 2'h0};
        link_mode_select = '0;
        lowpower_timeout_select = {2'h1, 2'h0};
        cs_n_in = 2'b11;
        sclk_in = '0;
        ctp_in = '0;
        ptc_in = 2'b11;
        repeat (20) @(posedge clk_sys);
        cmp({cs_n_oe_n, sclk_oe_n, ctp_oe_n, ptc_oe_n, line_oe_n, cs_n_out, timeout_alert_out,
             ptc_out}, 16'hFFF3);
        reset <= 1'b0;
        repeat (2) @(negedge clk_sys);
        cmp({cs_n_oe_n, sclk_oe_n, ctp_oe_n, ptc_oe_n, sclk_out[1]},
            16'h00AD);
        for (int i = 0; i < 90 && timeout_alert_out[0] !== 1'b1; i++) @(negedge clk_sys);
        cmp(timeout_alert_out, 16'h1);
        for (int k = 0; k < 3; k++)
        begin
            i_far.send(1'b0, wid[k]);
            repeat (4) @(negedge clk_sys);
            cmp({ptc_out[0], timeout_alert_out[0]}, exp_rx[k]);
        end
        @(posedge clk_sys);
        ptc_in <= 2'b01;
        cs_n_in <= 2'b10;
        chk_pulse(1'b0, 8'd15);
        cmp({cs_n_out[1], ptc_out[0]}, 16'h1);
        for (int i = 0; i < 90 && ptc_out[0] !== 1'b0; i++) @(negedge clk_sys);
        cmp(ptc_out[0], 16'h0);
        for (int b = 1; b >= 0; b--)
        begin
            @(posedge clk_sys);
            ptc_in <= {b[0], 1'b1};
            ctp_in <= {1'b0, b[0]};
            sclk_in <= 2'b01;
            chk_pulse(b[0], 8'd5);
            for (int i = 0; i < 90 && sclk_out[1] !== 1'b0; i++) @(negedge clk_sys);
            cmp(ctp_out[1], b[0]);
            repeat (40) @(negedge clk_sys);
            cmp({sclk_out[1], ptc_out[0]}, {1'b1, b[0]});
            @(posedge clk_sys);
            sclk_in <= 2'b00;
        end
        @(posedge clk_sys);
        cs_n_in <= 2'b11;
        chk_pulse(1'b1, 8'd15);
        for (int i = 0; i < 90 && cs_n_out[1] !== 1'b1; i++) @(negedge clk_sys);
        cmp({cs_n_out[1], ptc_out[0]}, 16'h3);
        @(posedge clk_sys);
        role_select_strap <= 2'b10;
        phase_polarity_select <= '0;
        repeat (3) @(negedge clk_sys);
        cmp({cs_n_oe_n, sclk_oe_n, ctp_oe_n, ptc_oe_n, sclk_out[1]}, 16'h00AD);
        // mid-run reset: peripheral recaptures unidirectional mode, so no return
        @(posedge clk_sys);
        reset <= 1'b1;
        role_select_strap <= 2'b01;
        link_mode_select <= {2'h2, 2'h0};
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cs_n_in <= 2'b10;
        chk_pulse(1'b0, 8'd15);
        repeat (60) @(negedge clk_sys);
        cmp({cs_n_out[1], ptc_out[0]}, 16'h1);
        end_sim;
    end
endmodule : spi_isolated_pulse_bridge_tb_top
